/* File: nv_sram_async_port_bench.sv */
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/100ps
module nv_sram_async_port_bench;
    import nvs_pkg::*;
    localparam logic [14:0] SEQ_A [0:4] = '{15'h0E38, 15'h31C7, 15'h03E0,
                                            15'h3C1F, 15'h303F};
    localparam logic [14:0] ST_LAST = 15'h0FC0;
    localparam logic [14:0] RC_LAST = 15'h0C63;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        req_i = 1'b0;
    logic        req_we_i = 1'b0;
    logic [14:0] req_addr_i = 15'h0000;
    logic [7:0]  req_wdata_i = 8'h00;
    logic        nv_req_i = 1'b0;
    logic        nv_store_i = 1'b0;
    logic        ready_o, rvalid_o, nv_busy_o, ce_b, we_b, oe_b, dq_oe, prev_ce;
    logic [7:0]  rdata_o, dq_o, dq_m, dq_bus;
    logic [14:0] addr, prev_addr;
    logic [14:0] ce_q [$];
    int          mismatches = 0;
    int          tests_run = 0;
    int          pin_bad = 0;
    int          addr_bad = 0;
    int          we_lows = 0;
    int          n_st, n_rc;

    always #50 clk_i = ~clk_i;
    assign dq_bus = dq_oe ? dq_o : dq_m;

    nvs_host_ctrl #(.POWERUP_CYC(20), .STORE_CYC(30), .SEQ_ADDR(SEQ_A),
        .SEQ_STORE_LAST(ST_LAST), .SEQ_RECALL_LAST(RC_LAST)) nvs_host_ctrl_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_we_i(req_we_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .nv_req_i(nv_req_i),
        .nv_store_i(nv_store_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
        .rdata_o(rdata_o), .nv_busy_o(nv_busy_o), .sram_addr_o(addr),
        .sram_ce_b_o(ce_b), .sram_we_b_o(we_b), .sram_oe_b_o(oe_b),
        .sram_dq_o(dq_o), .sram_dq_oe_o(dq_oe), .sram_dq_i(dq_bus));

    nvs_sram_model #(.SEQ_ADDR(SEQ_A), .SEQ_STORE_LAST(ST_LAST),
        .SEQ_RECALL_LAST(RC_LAST)) nvs_sram_model_i (
        .addr_i(addr), .ce_b_i(ce_b), .we_b_i(we_b), .oe_b_i(oe_b), .dq_i(dq_o),
        .dq_o(dq_m), .store_cnt_o(n_st), .recall_cnt_o(n_rc));

    // Pin watch: sees values registered at the previous edge
    always @(posedge clk_i) begin
        if (rst_b_i === 1'b1) begin
            if (ce_b === 1'b0 && we_b === oe_b) pin_bad++;
            if (addr !== prev_addr && prev_ce !== 1'b1) addr_bad++;
            if (prev_ce === 1'b1 && ce_b === 1'b0) ce_q.push_back(addr);
            if (we_b === 1'b0) we_lows++;
        end
        prev_addr = addr;
        prev_ce = ce_b;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic wait_lvl(input bit busy);
        int n;
        for (n = 0; n < 2000 && (busy ? nv_busy_o !== 1'b0 : ready_o !== 1'b1); n++) tick();
        if (n == 2000) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic do_req(input logic we, input logic [14:0] a, input logic [7:0] d);
        wait_lvl(0);
        req_i = 1'b1;
        req_we_i = we;
        req_addr_i = a;
        req_wdata_i = d;
        tick();
        req_i = 1'b0;
    endtask

    task automatic do_read(input logic [14:0] a, input logic [7:0] exp);
        int n;
        do_req(0, a, 8'h00);
        for (n = 0; n < 20 && rvalid_o !== 1'b1; n++) tick();
        chk(16'(n + 1), 16'h0005);
        chk(16'(rdata_o), 16'(exp));
    endtask

    task automatic nv_seq(input logic st);
        int w0;
        wait_lvl(0);
        ce_q.delete();
        w0 = we_lows;
        nv_store_i = st;
        nv_req_i = 1'b1;
        tick();
        nv_req_i = 1'b0;
        chk(16'(nv_busy_o), 16'h0001);
        wait_lvl(1);
        chk(16'(ce_q.size()), 16'h0006);
        for (int i = 0; i < 6 && i < ce_q.size(); i++)
            chk(16'(ce_q[i]), 16'(i < 5 ? SEQ_A[i] : (st ? ST_LAST : RC_LAST)));
        chk(16'(we_lows - w0), 16'h0000);
    endtask

    task automatic test_rw();
        do_req(1, 15'h0000, 8'hAA);
        do_req(1, 15'h7FFF, 8'h55);
        do_req(1, 15'h1234, 8'h3C);
        do_read(15'h7FFF, 8'h55);
        do_read(15'h0000, 8'hAA);
        do_read(15'h1234, 8'h3C);
        chk(16'(pin_bad), 16'h0000);
        chk(16'(addr_bad), 16'h0000);
        $display("test_rw done");
    endtask

    task automatic test_store_recall();
        int s0, r0;
        s0 = n_st;
        r0 = n_rc;
        do_req(1, 15'h0100, 8'h5A);
        nv_seq(1);
        do_req(1, 15'h0100, 8'hC3);
        chk(16'(nvs_sram_model_i.dirty), 16'h0000);
        do_read(15'h0100, 8'hC3);
        chk(16'(nvs_sram_model_i.dirty), 16'h0001);
        nv_seq(0);
        chk(16'(nvs_sram_model_i.dirty), 16'h0000);
        do_read(15'h0100, 8'h5A);
        chk(16'(n_st - s0), 16'h0001);
        chk(16'(n_rc - r0), 16'h0001);
        $display("test_store_recall done");
    endtask

    // Write held across a whole recall must wait, then land once
    task automatic test_refuse();
        wait_lvl(0);
        req_i = 1'b1;
        req_we_i = 1'b1;
        req_addr_i = 15'h0200;
        req_wdata_i = 8'h77;
        nv_seq(0);
        tick();
        req_i = 1'b0;
        do_read(15'h0200, 8'h77);
        chk(16'(pin_bad), 16'h0000);
        chk(16'(addr_bad), 16'h0000);
        $display("test_refuse done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        test_rw();
        test_store_recall();
        test_refuse();
        end_sim();
    end
endmodule

/* File: nvs_host_ctrl.sv */
// Host controller driving the pins of an asynchronous nonvolatile SRAM
// What this block does
// - Write strobe high on reads, low on writes
// - Address moves only while select or strobe high
// - Select held 20/30 ns before write end
// - Six reads at fixed addresses, in order
// - Write strobe high across all six reads
`timescale 1ns/100ps
module nvs_host_ctrl #(
    parameter int unsigned              POWERUP_CYC = nvs_pkg::POWERUP_RECALL_CYC,
    parameter int unsigned              STORE_CYC   = nvs_pkg::STORE_CYCLE_CYC,
    parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_ADDR [0:4] = '{15'h0001, 15'h0002,
                                                             15'h0003, 15'h0004, 15'h0005},
    parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_STORE_LAST  = 15'h0006,
    parameter logic [nvs_pkg::ADDR_W-1:0] SEQ_RECALL_LAST = 15'h0007
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       req_i,
    input  wire logic                       req_we_i,
    input  wire logic [nvs_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [nvs_pkg::DATA_W-1:0] req_wdata_i,
    input  wire logic                       nv_req_i,
    input  wire logic                       nv_store_i,
    output logic                            ready_o,
    output logic                            rvalid_o,
    output logic [nvs_pkg::DATA_W-1:0]      rdata_o,
    output logic                            nv_busy_o,
    output logic [nvs_pkg::ADDR_W-1:0]      sram_addr_o,
    output logic                            sram_ce_b_o,
    output logic                            sram_we_b_o,
    output logic                            sram_oe_b_o,
    output logic [nvs_pkg::DATA_W-1:0]      sram_dq_o,
    output logic                            sram_dq_oe_o,
    input  wire logic [nvs_pkg::DATA_W-1:0] sram_dq_i
);
    import nvs_pkg::*;
    if (POWERUP_CYC < 1 || STORE_CYC < 1 || STORE_CYC >= (1 << TIMER_W)) begin : g_chk
        $error("Wait counts out of range for the timer");
    end
    nvs_state_t        state;
    nvs_state_t        next_state;
    logic [2:0]        step_cnt;
    logic [2:0]        next_step_cnt;
    logic [2:0]        seq_ix;
    logic [2:0]        next_seq_ix;
    logic              seq_store;
    logic              next_seq_store;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic              ce_b;
    logic              next_ce_b;
    logic              we_b;
    logic              next_we_b;
    logic              oe_b;
    logic              next_oe_b;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] next_dq_out;
    logic              dq_oe;
    logic              next_dq_oe;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic              rvalid;
    logic              next_rvalid;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
    logic              tmr_load;
    logic [TIMER_W-1:0] tmr_count;
    logic              tmr_busy;
    nvs_wait_timer #(
        .W           (TIMER_W),
        .RESET_COUNT (POWERUP_CYC)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .busy_o  (tmr_busy)
    );
    // Data pins are asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dq_meta <= DATA_RESET;
            dq_sync <= DATA_RESET;
        end else begin
            dq_meta <= sram_dq_i;
            dq_sync <= dq_meta;
        end
    end
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] ix, input logic st);
        return (ix < SEQ_LAST_IX) ? SEQ_ADDR[ix] : (st ? SEQ_STORE_LAST : SEQ_RECALL_LAST);
    endfunction
    always_comb begin
        next_state     = state;
        next_step_cnt  = step_cnt;
        next_seq_ix    = seq_ix;
        next_seq_store = seq_store;
        next_addr      = addr;
        next_ce_b      = ce_b;
        next_we_b      = 1'b1;
        next_oe_b      = oe_b;
        next_dq_out    = dq_out;
        next_dq_oe     = 1'b0;
        next_rdata     = rdata;
        next_rvalid    = 1'b0;
        tmr_load       = 1'b0;
        tmr_count      = '0;
        case (state)
            ST_PWRUP: begin
                if (!tmr_busy) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Address moves here and in ST_SEQ_GAP, both with select high
                if (nv_req_i) begin
                    next_seq_ix    = 3'h0;
                    next_seq_store = nv_store_i;
                    next_addr      = seq_addr(3'h0, nv_store_i);
                    next_state     = ST_SEQ_SET;
                end else if (req_i && req_we_i) begin
                    next_addr   = req_addr_i;
                    next_dq_out = req_wdata_i;
                    next_state  = ST_WR_SET;
                end else if (req_i) begin
                    next_addr     = req_addr_i;
                    next_ce_b     = 1'b0;
                    next_oe_b     = 1'b0;
                    next_step_cnt = READ_HOLD_CYC;
                    next_state    = ST_RD_ACT;
                end
            end
            ST_RD_ACT: begin
                // Write strobe kept high, so the device drives data
                next_step_cnt = step_cnt - 3'h1;
                if (step_cnt == 3'h1) begin
                    next_ce_b  = 1'b1;
                    next_oe_b  = 1'b1;
                    next_state = ST_RD_DONE;
                end
            end
            ST_RD_DONE: begin
                // Idle cycle lets the device float before we may drive
                next_rdata  = dq_sync;
                next_rvalid = 1'b1;
                next_state  = ST_IDLE;
            end
            ST_WR_SET: begin
                next_ce_b  = 1'b0;
                next_we_b  = 1'b0;
                next_dq_oe = 1'b1;
                next_state = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                // One full clock of select and strobe covers 30 ns
                next_ce_b  = 1'b1;
                next_dq_oe = 1'b1;
                next_state = ST_WR_HOLD;
            end
            ST_WR_HOLD: begin
                next_state = ST_IDLE;
            end
            ST_SEQ_SET: begin
                next_ce_b  = 1'b0;
                next_oe_b  = 1'b0;
                next_state = ST_SEQ_ACT;
            end
            ST_SEQ_ACT: begin
                // Exactly one select pulse per step, never double clocked
                next_ce_b  = 1'b1;
                next_oe_b  = 1'b1;
                next_state = ST_SEQ_GAP;
            end
            ST_SEQ_GAP: begin
                if (seq_ix == SEQ_LAST_IX) begin
                    tmr_load   = 1'b1;
                    tmr_count  = seq_store ? TIMER_W'(STORE_CYC) : TIMER_W'(SOFT_RECALL_CYC);
                    next_state = ST_NV_WAIT;
                end else begin
                    next_seq_ix = seq_ix + 3'h1;
                    next_addr   = seq_addr(seq_ix + 3'h1, seq_store);
                    next_state  = ST_SEQ_SET;
                end
            end
            ST_NV_WAIT: begin
                if (!tmr_busy) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state     <= ST_PWRUP;
            step_cnt  <= 3'h0;
            seq_ix    <= 3'h0;
            seq_store <= 1'b0;
            addr      <= ADDR_RESET;
            ce_b      <= 1'b1;
            we_b      <= 1'b1;
            oe_b      <= 1'b1;
            dq_out    <= DATA_RESET;
            dq_oe     <= 1'b0;
            rdata     <= DATA_RESET;
            rvalid    <= 1'b0;
        end else begin
            state     <= next_state;
            step_cnt  <= next_step_cnt;
            seq_ix    <= next_seq_ix;
            seq_store <= next_seq_store;
            addr      <= next_addr;
            ce_b      <= next_ce_b;
            we_b      <= next_we_b;
            oe_b      <= next_oe_b;
            dq_out    <= next_dq_out;
            dq_oe     <= next_dq_oe;
            rdata     <= next_rdata;
            rvalid    <= next_rvalid;
        end
    end
    assign ready_o      = (state == ST_IDLE) && !nv_req_i;
    assign nv_busy_o    = (state == ST_SEQ_SET) || (state == ST_SEQ_ACT) ||
                          (state == ST_SEQ_GAP) || (state == ST_NV_WAIT);
    assign rvalid_o     = rvalid;
    assign rdata_o      = rdata;
    assign sram_addr_o  = addr;
    assign sram_ce_b_o  = ce_b;
    assign sram_we_b_o  = we_b;
    assign sram_oe_b_o  = oe_b;
    assign sram_dq_o    = dq_out;
    assign sram_dq_oe_o = dq_oe;
    // Helper: cycles since reset, saturating
    logic [TIMER_W-1:0] since_rst;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            since_rst <= '0;
        end else if (since_rst != '1) begin
            since_rst <= since_rst + TIMER_W'(1);
        end
    end
    AST_WE_HIGH_ON_READ: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !sram_oe_b_o |-> sram_we_b_o && !sram_dq_oe_o)
        else $error("Write strobe or data drive active during a read");
    AST_ADDR_MOVES_DESELECTED: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !$stable(sram_addr_o) |-> ($past(sram_ce_b_o) && (sram_ce_b_o || sram_we_b_o)))
        else $error("Address changed during a selected write");
    AST_WRITE_PULSE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(sram_we_b_o) |-> !sram_ce_b_o && sram_dq_oe_o
            ##1 (sram_ce_b_o && sram_we_b_o && sram_dq_oe_o) ##1 !sram_dq_oe_o)
        else $error("Write pulse shape wrong");
    AST_READ_SAMPLE_LATE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(sram_oe_b_o) && !nv_busy_o |-> !sram_oe_b_o [*3] ##1 sram_oe_b_o ##1 rvalid_o)
        else $error("Read data not sampled after synchroniser delay");
    AST_POWERUP_WAIT: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        ready_o |-> since_rst >= TIMER_W'(POWERUP_CYC))
        else $error("Accessed before power-up recall time");
    AST_SEQ_WE_HIGH: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        nv_busy_o |-> sram_we_b_o && !sram_dq_oe_o)
        else $error("Write strobe low during the trigger sequence");
    AST_SEQ_SINGLE_EDGE: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(sram_ce_b_o) && nv_busy_o |=> sram_ce_b_o [*2])
        else $error("Select pulse in trigger step not single");
    AST_SEQ_SIX_STEPS: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(state == ST_NV_WAIT) |-> $past(seq_ix) == SEQ_LAST_IX &&
            sram_addr_o == (seq_store ? SEQ_STORE_LAST : SEQ_RECALL_LAST))
        else $error("Trigger sequence ended early or on a wrong address");
    COV_READ: cover property (@(posedge clk_i) disable iff (!rst_b_i) rvalid_o);
    COV_WRITE: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(sram_we_b_o));
    COV_NV_DONE: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        (state == ST_NV_WAIT) ##1 (state == ST_IDLE));
endmodule

/* File: nvs_pkg.sv */
// Shared constants for the host-side nonvolatile SRAM port controller
package nvs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned ADDR_W        = 15;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned SEQ_LEN       = 6;
    localparam int unsigned TIMER_W       = 24;

    // Timing figures in their own units
    localparam int unsigned POWERUP_RECALL_TIME_US = 550;
    localparam int unsigned SOFT_RECALL_TIME_US    = 20;
    localparam int unsigned STORE_CYCLE_TIME_MS    = 10;
    localparam int unsigned READ_ACCESS_NS         = 45;
    localparam int unsigned SYNC_STAGES            = 2;

    // Waits are least times, so every count rounds up
    localparam int unsigned POWERUP_RECALL_CYC =
        (POWERUP_RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SOFT_RECALL_CYC =
        (SOFT_RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STORE_CYCLE_CYC =
        (STORE_CYCLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_ACCESS_CYC =
        (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Chip select stays low until data has crossed the synchroniser
    localparam logic [2:0]  READ_HOLD_CYC = 3'(READ_ACCESS_CYC + SYNC_STAGES);

    localparam logic [ADDR_W-1:0] ADDR_RESET  = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
    localparam logic [2:0]        SEQ_LAST_IX = 3'h5;

    typedef enum logic [10:0] {
        ST_PWRUP    = 11'h001,
        ST_IDLE     = 11'h002,
        ST_RD_ACT   = 11'h004,
        ST_RD_DONE  = 11'h008,
        ST_WR_SET   = 11'h010,
        ST_WR_PULSE = 11'h020,
        ST_WR_HOLD  = 11'h040,
        ST_SEQ_SET  = 11'h080,
        ST_SEQ_ACT  = 11'h100,
        ST_SEQ_GAP  = 11'h200,
        ST_NV_WAIT  = 11'h400
    } nvs_state_t;
endpackage

/* File: nvs_sram_model.sv */
// Behavioural nonvolatile SRAM answering the host controller pins
`timescale 1ns/100ps
module nvs_sram_model
    import nvs_pkg::*;
#(
    parameter logic [ADDR_W-1:0] SEQ_ADDR [0:4]  = '{15'h0001, 15'h0002, 15'h0003,
                                                     15'h0004, 15'h0005},
    parameter logic [ADDR_W-1:0] SEQ_STORE_LAST  = 15'h0006,
    parameter logic [ADDR_W-1:0] SEQ_RECALL_LAST = 15'h0007
) (
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              ce_b_i,
    input  wire logic              we_b_i,
    input  wire logic              oe_b_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0]      dq_o,
    output int                     store_cnt_o,
    output int                     recall_cnt_o
);
    logic [DATA_W-1:0] mem [0:32767];
    logic [DATA_W-1:0] nv  [0:32767];
    logic              we_led;
    logic              wr_act;
    logic              rd_en;
    logic              standby;
    logic              dirty;
    int                step;

    initial begin
        dq_o = 8'h00;
        we_led = 1'b0;
        dirty = 1'b0;
        wr_act = 1'b0;
        step = 0;
        store_cnt_o = 0;
        recall_cnt_o = 0;
        for (int i = 0; i < 32768; i++) begin
            nv[i] = 8'hFF;
            mem[i] = nv[i];
        end
    end

    assign standby = ce_b_i;
    assign rd_en = !ce_b_i && !oe_b_i && we_b_i && !we_led;

    // Released bus shows the inverse so stale data never passes as fresh
    always @(rd_en or addr_i) begin
        if (rd_en) begin
            dq_o <= #10 mem[addr_i];
        end else begin
            dq_o <= #10 ~dq_o;
        end
    end

    always @(negedge we_b_i) begin
        if (!ce_b_i) begin
            wr_act = 1'b1;
        end
    end

    always @(posedge ce_b_i or posedge we_b_i) begin
        if (wr_act) begin
            mem[addr_i] = dq_i;
            // Power-down store would be skipped while this stays clear
            dirty = 1'b1;
            wr_act = 1'b0;
        end
    end

    always @(negedge ce_b_i) begin
        // Host moves select and strobe on one edge, so let both settle
        #1;
        we_led = !we_b_i;
        if (!we_b_i) begin
            wr_act = 1'b1;
            step = 0;
        end else if (step < 5 && addr_i == SEQ_ADDR[step]) begin
            step++;
        end else if (step == 5 && addr_i == SEQ_STORE_LAST) begin
            for (int i = 0; i < 32768; i++) nv[i] = mem[i];
            store_cnt_o++;
            dirty = 1'b0;
            step = 0;
        end else if (step == 5 && addr_i == SEQ_RECALL_LAST) begin
            for (int i = 0; i < 32768; i++) mem[i] = nv[i];
            recall_cnt_o++;
            dirty = 1'b0;
            step = 0;
        end else begin
            step = (addr_i == SEQ_ADDR[0]) ? 1 : 0;
        end
    end
endmodule

/* File: nvs_wait_timer.sv */
// Down-counting wait timer for the long nonvolatile waits
`timescale 1ns/100ps
module nvs_wait_timer #(
    parameter int unsigned W           = 24,
    parameter int unsigned RESET_COUNT = 5500
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              busy_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    if (RESET_COUNT >= (64'h1 << W)) begin : g_chk
        $error("Reset count does not fit timer width");
    end

    always_comb begin
        next_cnt = cnt;
        if (load_i) begin
            next_cnt = count_i;
        end else if (cnt != '0) begin
            next_cnt = cnt - W'(1);
        end
    end

    // Reset starts the power-up wait with no help from the controller
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt <= W'(RESET_COUNT);
        end else begin
            cnt <= next_cnt;
        end
    end

    assign busy_o = (cnt != '0);
endmodule
